//--- shared/supervisor_pkg.sv
/*
 Constants, state type and timing counts for the converter supervisor.
 Assumes a 10 MHz system clock and digitised analog measurements from outside.
*/
// How it works
// - Stop switching above 108% of setpoint
// - Overvoltage beyond 100ms forces high-impedance idle
// - Drop select: off, 100, 200, 300 mV
// - Setpoint rises linearly with load, full at 2.4A
// - Light-load off needs buck, headroom, low output
// - Enable bit arms light-load shutdown
// - Low current past delay enters light-load off
// - Light-load off holds until powered mode re-entered
// - Setpoint writes slew at selected rate
// - Downstep sink on while lowering, off at regulation
// - Overvoltage sink active during overvoltage when enabled
// - Three-bit status reports live state
// - Status reads zero outside powered mode
// - Switching frequency fixed, not user writable
// - Output under 3V: fault_retry_state 3s, then restart
// - Current-regulation flag mirrors current loop in powered mode, zero outside it
package supervisor_pkg;
   // ==========================================
   // Scales: setpoint and voltages in 10 mV steps, current in 1 mA steps
   localparam int SETPOINT_W = 11;
   localparam int CURRENT_W = 13;
   localparam int CLOCK_HZ = 10_000_000;
   localparam int OV_PERCENT = 108;
   localparam int OV_TIME_MS = 100;
   localparam int FAULT_RETRY_STATE_TIME_S = 3;
   localparam int LL_STEP_S = 10;
   localparam int LL_CURRENT_MA = 5;
   localparam logic [SETPOINT_W-1:0] UV_LIMIT = 11'h12C; // 3 V
   localparam logic [SETPOINT_W-1:0] LL_VOUT_MAX = 11'h258; // 6 V
   localparam logic [SETPOINT_W-1:0] LL_HEADROOM = 11'h032; // 0.5 V
   localparam logic [CURRENT_W-1:0] COMP_FULL_MA = 13'h0960; // 2.4 A
   localparam logic [SETPOINT_W-1:0] SETPOINT_RESET = 11'h1F4; // 5 V
   localparam int FSW_KHZ = 500;
   localparam int OV_CYCLES = CLOCK_HZ / 1000 * OV_TIME_MS;
   localparam int FAULT_RETRY_STATE_CYCLES = CLOCK_HZ * FAULT_RETRY_STATE_TIME_S;
   localparam int LL_STEP_CYCLES = CLOCK_HZ * LL_STEP_S;
   localparam int SS_STEP_CYCLES = 100;
   localparam int TIMER_W = 32;
   // ==========================================
   // Status codes
   localparam logic [2:0] ST_RESTART = 3'h0;
   localparam logic [2:0] ST_SOFTSTART = 3'h1;
   localparam logic [2:0] ST_REGULATE = 3'h2;
   localparam logic [2:0] ST_FAULT = 3'h3;
   localparam logic [2:0] ST_LLOFF = 3'h4;
   typedef enum logic [2:0] {
      RESTART_S, SOFT_START_S, REGULATE_S, FAULT_RETRY_S, LIGHT_LOAD_OFF_S, IDLE_S
   } state_t;
endpackage

//--- hw/setpoint_slew.sv
/*
 Setpoint ramp generator: walks the working target one step per tick toward a goal.
 Assumes goal and slew select are synchronous to CLOCK_I.
*/
`timescale 1ns/100ps
module setpoint_slew (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic restart_i,
   input wire logic [supervisor_pkg::SETPOINT_W-1:0] goal_i,
   input wire logic [1:0] slew_select_i,
   output logic [supervisor_pkg::SETPOINT_W-1:0] target_o,
   output logic settled_o,
   output logic falling_o
);
   import supervisor_pkg::*;
   logic [15:0] tick_ff;
   logic [SETPOINT_W-1:0] target_ff;
   wire [15:0] tick_len = 16'h0064 << slew_select_i; // Slower code, longer step
   wire tick_done = (tick_ff >= tick_len);
   wire up = goal_i > target_ff;
   wire down = goal_i < target_ff;
   wire [SETPOINT_W-1:0] nxt_target = up ? target_ff + 11'h001 :
                                      down ? target_ff - 11'h001 : target_ff;
   assign target_o = target_ff;
   assign settled_o = !up && !down;
   assign falling_o = down;
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         tick_ff <= 16'h0000;
         target_ff <= 11'h000;
      end else if (restart_i) begin
         // Unpowered: load the goal at once, the soft-start ramp does the rise
         tick_ff <= 16'h0000;
         target_ff <= goal_i;
      end else begin
         tick_ff <= tick_done ? 16'h0000 : tick_ff + 16'h0001;
         if (tick_done) target_ff <= nxt_target;
      end
   end
endmodule

//--- hw/converter_supervisor_fsm.sv
/*
 Power-on supervisor: overvoltage, drop compensation, light-load off, setpoint
 slew, sink control and status. Assumes measurements arrive as sampled codes
 from other clocks, so each passes two flip-flops.
*/
`timescale 1ns/100ps
module converter_supervisor_fsm #(
   parameter int OV_CYC = supervisor_pkg::OV_CYCLES,
   parameter int FAULT_RETRY_STATE_CYC = supervisor_pkg::FAULT_RETRY_STATE_CYCLES,
   parameter int LL_STEP_CYC = supervisor_pkg::LL_STEP_CYCLES,
   parameter int SS_STEP_CYC = supervisor_pkg::SS_STEP_CYCLES
) (
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   input wire logic ENABLE_I,
   input wire logic [supervisor_pkg::SETPOINT_W-1:0] OUTPUT_SETPOINT_I,
   input wire logic [1:0] SLEW_SELECT_I,
   input wire logic [1:0] DROP_COMP_SELECT_I,
   input wire logic LIGHT_LOAD_ENABLE_I,
   input wire logic [1:0] LIGHT_LOAD_DELAY_SELECT_I,
   input wire logic DOWNSTEP_SINK_ENABLE_I,
   input wire logic OVERVOLTAGE_SINK_ENABLE_I,
   input wire logic [supervisor_pkg::SETPOINT_W-1:0] VOUT_MEAS_I,
   input wire logic [supervisor_pkg::SETPOINT_W-1:0] VIN_MEAS_I,
   input wire logic [supervisor_pkg::CURRENT_W-1:0] IOUT_MEAS_I,
   input wire logic BUCK_MODE_I,
   input wire logic CURRENT_LOOP_I,
   output logic SWITCH_ENABLE_O,
   output logic HIGH_IMPEDANCE_IDLE_O,
   output logic [supervisor_pkg::SETPOINT_W-1:0] REG_TARGET_O,
   output logic DOWNSTEP_SINK_O,
   output logic OVERVOLTAGE_SINK_O,
   output logic [2:0] STATUS_O,
   output logic CURRENT_REGULATION_FLAG_O
);
   import supervisor_pkg::*;
   // ==========================================
   // Input synchronisers, one generate over the packed pin bits
   localparam int SYNC_W = 2 * SETPOINT_W + CURRENT_W + 3;
   logic [SYNC_W-1:0] meta_ff;
   logic [SYNC_W-1:0] sync_ff;
   wire [SYNC_W-1:0] raw = {VOUT_MEAS_I, VIN_MEAS_I, IOUT_MEAS_I,
                            BUCK_MODE_I, CURRENT_LOOP_I, ENABLE_I};
   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++) begin : sync_g
         always_ff @(posedge CLOCK_I or posedge RESET_I) begin
            if (RESET_I) begin
               meta_ff[g] <= 1'b0;
               sync_ff[g] <= 1'b0;
            end else begin
               meta_ff[g] <= raw[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate
   wire [SETPOINT_W-1:0] vout = sync_ff[SYNC_W-1 -: SETPOINT_W];
   wire [SETPOINT_W-1:0] vin = sync_ff[SYNC_W-1-SETPOINT_W -: SETPOINT_W];
   wire [CURRENT_W-1:0] iout = sync_ff[CURRENT_W+2 : 3];
   wire buck = sync_ff[2];
   wire cur_loop = sync_ff[1];
   wire enable = sync_ff[0];
   // ==========================================
   // Setpoint slew and drop compensation
   logic [SETPOINT_W-1:0] slew_target;
   logic settled;
   logic falling;
   state_t state_ff;
   wire powered = enable && (state_ff != IDLE_S);
   setpoint_slew slew_u (
      .clock_i(CLOCK_I),
      .reset_i(RESET_I),
      .restart_i(!enable),
      .goal_i(OUTPUT_SETPOINT_I),
      .slew_select_i(SLEW_SELECT_I),
      .target_o(slew_target),
      .settled_o(settled),
      .falling_o(falling)
   );
   // Comp in 10 mV steps: code*10 steps at full load, linear in current
   wire [CURRENT_W-1:0] iclip = (iout > COMP_FULL_MA) ? COMP_FULL_MA : iout;
   // Ten steps per code; five bits hold the largest value of 30
   wire [4:0] comp_full = {DROP_COMP_SELECT_I, 3'h0} + {2'h0, DROP_COMP_SELECT_I, 1'h0};
   wire [16:0] comp_prod = 17'(iclip) * 17'(comp_full);
   wire [SETPOINT_W-1:0] comp = SETPOINT_W'(comp_prod / 17'(COMP_FULL_MA));
   wire [SETPOINT_W-1:0] target = slew_target + comp;
   // ==========================================
   // Overvoltage, undervoltage, light-load detection
   wire [17:0] ov_lhs = 18'(vout) * 18'd100;
   wire [17:0] ov_rhs = 18'(target) * 18'(OV_PERCENT);
   wire ov = ov_lhs > ov_rhs;
   wire uv = vout < UV_LIMIT;
   // One extra bit so a high output cannot wrap the headroom sum
   wire [SETPOINT_W:0] vout_headroom = {1'b0, vout} + {1'b0, LL_HEADROOM};
   wire ll_window = buck && ({1'b0, vin} >= vout_headroom) && (vout < LL_VOUT_MAX);
   wire ll_low = LIGHT_LOAD_ENABLE_I && ll_window && (iout < CURRENT_W'(LL_CURRENT_MA));
   wire [1:0] ll_mult = (LIGHT_LOAD_DELAY_SELECT_I == 2'h0) ? 2'h1 :
                        (LIGHT_LOAD_DELAY_SELECT_I == 2'h1) ? 2'h2 : 2'h3;
   wire [TIMER_W-1:0] ll_limit = TIMER_W'(LL_STEP_CYC) * TIMER_W'(ll_mult);
   logic [TIMER_W-1:0] ov_cnt_ff;
   logic [TIMER_W-1:0] ll_cnt_ff;
   logic [TIMER_W-1:0] st_cnt_ff;
   logic [SETPOINT_W-1:0] ss_level_ff;
   logic [7:0] ss_tick_ff;
   // Own step counter: the state counter keeps running and would alias the step
   wire ss_step = ss_tick_ff == 8'(SS_STEP_CYC - 1);
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ov_cnt_ff <= '0;
         ll_cnt_ff <= '0;
      end else begin
         ov_cnt_ff <= (ov && powered) ? ov_cnt_ff + 1'b1 : '0;
         ll_cnt_ff <= (ll_low && state_ff == REGULATE_S) ? ll_cnt_ff + 1'b1 : '0;
      end
   end
   wire ov_expired = ov_cnt_ff >= TIMER_W'(OV_CYC);
   wire ll_expired = ll_cnt_ff >= ll_limit;
   // ==========================================
   // Power-on state machine
   state_t nxt_state;
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         RESTART_S: nxt_state = SOFT_START_S;
         SOFT_START_S: if (uv && ss_level_ff >= target) nxt_state = FAULT_RETRY_S;
            else if (ss_level_ff >= target) nxt_state = REGULATE_S;
         REGULATE_S: if (uv) nxt_state = FAULT_RETRY_S;
            else if (ll_expired) nxt_state = LIGHT_LOAD_OFF_S;
         FAULT_RETRY_S: if (st_cnt_ff >= TIMER_W'(FAULT_RETRY_STATE_CYC)) nxt_state = RESTART_S;
         LIGHT_LOAD_OFF_S: nxt_state = LIGHT_LOAD_OFF_S;
         IDLE_S: nxt_state = IDLE_S;
      endcase
      if (ov_expired) nxt_state = IDLE_S;
      if (!enable) nxt_state = RESTART_S;
   end
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state_ff <= RESTART_S;
         st_cnt_ff <= '0;
         ss_level_ff <= '0;
         ss_tick_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         st_cnt_ff <= (nxt_state != state_ff) ? '0 : st_cnt_ff + 1'b1;
         if (state_ff != SOFT_START_S) begin
            ss_level_ff <= '0;
            ss_tick_ff <= 8'h00;
         end else begin
            ss_tick_ff <= ss_step ? 8'h00 : ss_tick_ff + 8'h01;
            if (ss_step) ss_level_ff <= ss_level_ff + 11'h010;
         end
      end
   end
   // ==========================================
   // Outputs; switching frequency has no control here at all
   wire [2:0] status_code = !powered ? ST_RESTART :
      (state_ff == SOFT_START_S) ? ST_SOFTSTART :
      (state_ff == REGULATE_S) ? ST_REGULATE :
      (state_ff == FAULT_RETRY_S) ? ST_FAULT :
      (state_ff == LIGHT_LOAD_OFF_S) ? ST_LLOFF : ST_RESTART;
   wire run = powered && (state_ff == SOFT_START_S || state_ff == REGULATE_S);
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         SWITCH_ENABLE_O <= 1'b0;
         HIGH_IMPEDANCE_IDLE_O <= 1'b1;
         REG_TARGET_O <= '0;
         DOWNSTEP_SINK_O <= 1'b0;
         OVERVOLTAGE_SINK_O <= 1'b0;
         STATUS_O <= 3'h0;
         CURRENT_REGULATION_FLAG_O <= 1'b0;
      end else begin
         SWITCH_ENABLE_O <= run && !ov;
         HIGH_IMPEDANCE_IDLE_O <= !powered;
         REG_TARGET_O <= (state_ff == SOFT_START_S && ss_level_ff < target) ? ss_level_ff
                         : target;
         DOWNSTEP_SINK_O <= DOWNSTEP_SINK_ENABLE_I && run && (falling || vout > target);
         OVERVOLTAGE_SINK_O <= OVERVOLTAGE_SINK_ENABLE_I && ov && powered;
         STATUS_O <= status_code;
         CURRENT_REGULATION_FLAG_O <= powered && cur_loop;
      end
   end
   // ==========================================
   // Checks
   ov_switch_off_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
      ov |=> !SWITCH_ENABLE_O) else $error("switching during overvoltage");
   ov_idle_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
      ov_expired && enable |=> state_ff == IDLE_S) else $error("no idle after overvoltage");
   status_off_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
      !powered |=> STATUS_O == 3'h0) else $error("status nonzero while off");
   ll_hold_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
      state_ff == LIGHT_LOAD_OFF_S && enable && !ov_expired |=> state_ff == LIGHT_LOAD_OFF_S)
      else $error("left light-load off");
   ll_arm_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
      !LIGHT_LOAD_ENABLE_I |-> ll_cnt_ff == '0 || $past(LIGHT_LOAD_ENABLE_I))
      else $error("light-load timer ran while disarmed");
   restart_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
      state_ff == RESTART_S && enable && !ov_expired |=> state_ff == SOFT_START_S)
      else $error("restart did not enter soft-start");
   ov_sink_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
      OVERVOLTAGE_SINK_ENABLE_I && ov && powered |=> OVERVOLTAGE_SINK_O)
      else $error("overvoltage sink missing");
   fault_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
      state_ff == REGULATE_S && uv && enable && !ov_expired |=> state_ff == FAULT_RETRY_S)
      else $error("undervoltage not caught");
endmodule

//--- verification/plant_model.sv
/*
 Output node model standing in for the power stage and load at the far side.
 Assumes the bench drives the force inputs on the falling edge of the clock.
*/
`timescale 1ns/100ps
module plant_model (
   input wire logic clock_i,
   input wire logic switch_enable_i,
   input wire logic [supervisor_pkg::SETPOINT_W-1:0] target_i,
   input wire logic force_i,
   input wire logic [supervisor_pkg::SETPOINT_W-1:0] force_level_i,
   output logic [supervisor_pkg::SETPOINT_W-1:0] vout_o
);
   import supervisor_pkg::*;
   // ==========================================
   // Output node
   // Load drains the node once switching stops, so a stale level never lingers
   logic [SETPOINT_W-1:0] level_ff = 11'h000;
   // Rising edge, so the node never races the bench's falling-edge drive
   always @(posedge clock_i) begin
      level_ff <= force_i ? force_level_i : (switch_enable_i ? target_i : 11'h000);
   end
   assign vout_o = level_ff;
endmodule

//--- verification/converter_supervisor_fsm_tb.sv
/*
 Self-checking bench for the converter supervisor with shortened timing counts.
 Assumes the plant model closes the loop from regulation target to measured output.
*/
`timescale 1ns/100ps
module converter_supervisor_fsm_tb;
   import supervisor_pkg::*;
   // ==========================================
   // Stimulus and wiring
   localparam int LL_CYC = 100;
   localparam int HIC_CYC = 50;
   logic clock_i = 1'b0, reset_i = 1'b1, enable_i = 1'b0, force_i = 1'b0;
   logic ll_en = 1'b0, down_en = 1'b0, ov_en = 1'b1, buck = 1'b1, cloop = 1'b0;
   logic [1:0] slew = 2'h0, comp = 2'h0, delay = 2'h0;
   logic [10:0] setpoint = 11'h1F4, vin = 11'h4B0, force_lvl = 11'h000, vout, target;
   logic [12:0] iout = 13'h03E8;
   logic sw_en, high_impedance_idle, down_sink, ov_sink, cc_flag;
   logic [2:0] status;
   int n_mismatch = 0, total_checks = 0, sp;
   converter_supervisor_fsm #(.OV_CYC(20), .FAULT_RETRY_STATE_CYC(HIC_CYC), .LL_STEP_CYC(LL_CYC),
      .SS_STEP_CYC(4)) u_dut (.CLOCK_I(clock_i), .RESET_I(reset_i), .ENABLE_I(enable_i),
      .OUTPUT_SETPOINT_I(setpoint), .SLEW_SELECT_I(slew), .DROP_COMP_SELECT_I(comp),
      .LIGHT_LOAD_ENABLE_I(ll_en), .LIGHT_LOAD_DELAY_SELECT_I(delay),
      .DOWNSTEP_SINK_ENABLE_I(down_en), .OVERVOLTAGE_SINK_ENABLE_I(ov_en),
      .VOUT_MEAS_I(vout), .VIN_MEAS_I(vin), .IOUT_MEAS_I(iout), .BUCK_MODE_I(buck),
      .CURRENT_LOOP_I(cloop), .SWITCH_ENABLE_O(sw_en), .HIGH_IMPEDANCE_IDLE_O(high_impedance_idle),
      .REG_TARGET_O(target), .DOWNSTEP_SINK_O(down_sink), .OVERVOLTAGE_SINK_O(ov_sink),
      .STATUS_O(status), .CURRENT_REGULATION_FLAG_O(cc_flag));
   plant_model u_plant (.clock_i(clock_i), .switch_enable_i(sw_en), .target_i(target),
      .force_i(force_i), .force_level_i(force_lvl), .vout_o(vout));
   initial begin
      forever #50 clock_i = ~clock_i;
   end
   // ==========================================
   // Helpers
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic wait_on(input bit on_tgt, input logic [10:0] exp, input int lim);
      int i;
      for (i = 0; i < lim && (on_tgt ? target : {8'h00, status}) !== exp; i++) cyc(1);
      chk(on_tgt ? "target" : "status", on_tgt ? {5'h00, target} : {13'h0, status},
         {5'h00, exp});
   endtask
   task automatic power_up();
      enable_i = 1'b0;
      cyc(5);
      enable_i = 1'b1;
      wait_on(0, ST_SOFTSTART, 20);
      wait_on(0, ST_REGULATE, 600);
   endtask
   function automatic int ll_steps(input logic [1:0] code);
      return code == 2'h0 ? 1 : (code == 2'h1 ? 2 : 3);
   endfunction
   task automatic summarize();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      int i;
      void'($urandom(12838));
      cyc(10);
      chk("idle in reset", {15'h0, high_impedance_idle}, 16'h0001);
      chk("status in reset", {13'h0, status}, 16'h0000);
      reset_i = 1'b0;
      power_up();
      chk("switching", {15'h0, sw_en}, 16'h0001);
      cloop = 1'b1;
      cyc(5);
      chk("cc flag", {15'h0, cc_flag}, 16'h0001);
      cloop = 1'b0;
      cyc(5);
      chk("cc flag", {15'h0, cc_flag}, 16'h0000);
      // Random setpoint keeps the slewed walk short
      sp = 490 + $urandom_range(20);
      setpoint = 11'(sp);
      for (int c = 0; c < 4; c++) begin
         for (int h = 1; h <= 2; h++) begin
            comp = 2'(c);
            iout = 13'(2400 / h);
            wait_on(1, 11'(sp + c * 10 / h), 3000);
         end
      end
      comp = 2'h0;
      iout = 13'h03E8;
      wait_on(1, 11'(sp), 3000);
      down_en = 1'b1;
      setpoint = 11'(sp - 20);
      cyc(10);
      chk("downstep sink", {15'h0, down_sink}, 16'h0001);
      cyc(1490);
      chk("slew pace", {15'h0, target == 11'(sp - 20)}, 16'h0000);
      wait_on(1, 11'(sp - 20), 1000);
      for (i = 0; i < 50 && down_sink !== 1'b0; i++) cyc(1);
      chk("downstep sink", {15'h0, down_sink}, 16'h0000);
      sp = sp - 20;
      force_i = 1'b1;
      force_lvl = 11'(sp * 108 / 100 - 1);
      cyc(10);
      chk("below ov", {15'h0, sw_en}, 16'h0001);
      force_lvl = 11'(sp * 108 / 100 + 1);
      cyc(4);
      chk("ov stop", {15'h0, sw_en}, 16'h0000);
      chk("ov sink", {15'h0, ov_sink}, 16'h0001);
      cyc(12);
      chk("ov early idle", {15'h0, high_impedance_idle}, 16'h0000);
      cyc(14);
      chk("ov idle", {15'h0, high_impedance_idle}, 16'h0001);
      chk("idle status", {13'h0, status}, 16'h0000);
      force_i = 1'b0;
      cyc(20);
      chk("idle holds", {15'h0, high_impedance_idle}, 16'h0001);
      power_up();
      force_i = 1'b1;
      force_lvl = 11'h0FA;
      wait_on(0, ST_FAULT, 10);
      cyc(HIC_CYC - 10);
      chk("fault_retry_state holds", {13'h0, status}, {13'h0, ST_FAULT});
      force_i = 1'b0;
      wait_on(0, ST_REGULATE, 600);
      iout = 13'h0002;
      cyc(400);
      chk("ll disarmed", {13'h0, status}, {13'h0, ST_REGULATE});
      ll_en = 1'b1;
      buck = 1'b0;
      cyc(400);
      chk("ll not buck", {13'h0, status}, {13'h0, ST_REGULATE});
      buck = 1'b1;
      vin = 11'(sp + 40);
      cyc(400);
      chk("ll headroom", {13'h0, status}, {13'h0, ST_REGULATE});
      vin = 11'h4B0;
      for (int c = 0; c < 4; c++) begin
         delay = 2'(c);
         power_up();
         cyc(ll_steps(delay) * LL_CYC - 10);
         chk("ll early", {13'h0, status}, {13'h0, ST_REGULATE});
         wait_on(0, ST_LLOFF, 30);
         chk("ll output off", {15'h0, sw_en}, 16'h0000);
         cyc(50);
         chk("ll holds", {13'h0, status}, {13'h0, ST_LLOFF});
      end
      summarize();
   end
   initial begin
      #(60000 * 100);
      n_mismatch++;
      summarize();
   end
endmodule
